// file: bench/dsw_mem_model.sv
/*
 * behavioural program memory, ram page 2 and two eeprom pages.
 * assumes strobes from dsw_top; answers combinationally while strobed.
 */
`timescale 1ns/10ps
module dsw_mem_model (
	input wire logic clk_i,
	input wire logic [11:0] prog_addr_i,
	input wire logic prog_rd_i,
	output logic [7:0] prog_rdata_o,
	input wire logic [7:0] mem_addr_i,
	input wire logic [7:0] mem_wdata_i,
	input wire logic mem_wr_i,
	input wire logic ram2_sel_i,
	input wire logic ee0_sel_i,
	input wire logic ee1_sel_i,
	output logic [7:0] ram2_rdata_o,
	output logic [7:0] ee_rdata_o
);
	logic [7:0] ram2 [64];
	logic [7:0] ee0 [64];
	logic [7:0] ee1 [64];
	logic [7:0] noise = 8'h5a;
	logic [5:0] o;

	// unselected lines wander so a stale byte never looks valid
	always @(posedge clk_i) begin
		noise <= noise + 8'h3b;
		if (mem_wr_i && ram2_sel_i) ram2[o] <= mem_wdata_i;
		if (mem_wr_i && ee0_sel_i) ee0[o] <= mem_wdata_i;
		if (mem_wr_i && ee1_sel_i) ee1[o] <= mem_wdata_i;
	end

	// program byte is a fixed scramble of its address
	assign o = mem_addr_i[5:0];
	assign prog_rdata_o = prog_rd_i ?
		({prog_addr_i[3:0], prog_addr_i[11:8]} ^ prog_addr_i[7:0]) : noise;
	assign ram2_rdata_o = ram2_sel_i ? ram2[o] : ~noise;
	assign ee_rdata_o = ee0_sel_i ? ee0[o] : ee1_sel_i ? ee1[o] : ~noise;
endmodule : dsw_mem_model

// file: bench/dsw_top_tb.sv
/*
 * self-checking bench for dsw_top: window reads, bank codes, refusals.
 * assumes dsw_mem_model stands in for the memories.
 */
`timescale 1ns/10ps
`include "dsw_params.svh"
module dsw_top_tb;
	logic clk_i = 0, srst_i = 1, cpu_rd_i = 0, cpu_wr_i = 0;
	logic cpu_bitop_i = 0, nv_standby_i = 0;
	logic [7:0] cpu_addr_i = 0, cpu_wdata_i = 0, ext_rdata_i = 0;
	logic [7:0] cpu_rdata_o, mem_addr_o, mem_wdata_o, prog_rdata_i;
	logic [7:0] ram2_rdata_i, ee_rdata_i, s_ma, s_rd, page, d, off;
	logic cpu_rvalid_o, prog_rd_o, mem_wr_o, ram2_sel_o, ee0_sel_o;
	logic ee1_sel_o, local_sel_o, periph_sel_o, wo_misuse_o;
	logic s_prd, s_wr, s_per, s_mis, s_rv, s_loc;
	logic [11:0] prog_addr_o, s_pa;
	logic [1:0] artimer_sel_o, s_art;
	logic [2:0] s_sel;
	// software sets at most one bit, so reserved codes are single bits too
	logic [7:0] codes [8] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h04, 8'h08,
		8'h20, 8'h80};
	int n_fail = 0, checks_done = 0, cyc = 0;

	dsw_top #(.EE_PAGES(2)) dsw_top_i (.clk_i(clk_i), .srst_i(srst_i),
		.cpu_addr_i(cpu_addr_i), .cpu_rd_i(cpu_rd_i), .cpu_wr_i(cpu_wr_i),
		.cpu_bitop_i(cpu_bitop_i), .cpu_wdata_i(cpu_wdata_i),
		.cpu_rdata_o(cpu_rdata_o), .cpu_rvalid_o(cpu_rvalid_o),
		.prog_addr_o(prog_addr_o), .prog_rd_o(prog_rd_o),
		.prog_rdata_i(prog_rdata_i), .mem_addr_o(mem_addr_o),
		.mem_wdata_o(mem_wdata_o), .mem_wr_o(mem_wr_o),
		.ram2_sel_o(ram2_sel_o), .ee0_sel_o(ee0_sel_o),
		.ee1_sel_o(ee1_sel_o), .ram2_rdata_i(ram2_rdata_i),
		.ee_rdata_i(ee_rdata_i), .nv_standby_i(nv_standby_i),
		.local_sel_o(local_sel_o), .periph_sel_o(periph_sel_o),
		.artimer_sel_o(artimer_sel_o), .ext_rdata_i(ext_rdata_i),
		.wo_misuse_o(wo_misuse_o));

	dsw_mem_model dsw_mem_model_i (.clk_i(clk_i), .prog_addr_i(prog_addr_o),
		.prog_rd_i(prog_rd_o), .prog_rdata_o(prog_rdata_i),
		.mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
		.mem_wr_i(mem_wr_o), .ram2_sel_i(ram2_sel_o), .ee0_sel_i(ee0_sel_o),
		.ee1_sel_i(ee1_sel_o), .ram2_rdata_o(ram2_rdata_i),
		.ee_rdata_o(ee_rdata_i));

	// 200 MHz core clock
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end

	// hang guard: the whole run needs well under a thousand cycles
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [7:0] pbyte(input logic [11:0] a);
		return {a[3:0], a[11:8]} ^ a[7:0];
	endfunction : pbyte

	// only the three exact codes map a page: {ram2, ee0, ee1}
	function automatic logic [2:0] exp_sel(input logic [7:0] c);
		case (c)
			8'h10: return 3'b100;
			8'h01: return 3'b010;
			8'h02: return 3'b001;
			default: return 3'b000;
		endcase
	endfunction : exp_sel

	// one request; captures the strobe cycle and the answer cycle
	task automatic op(input logic rd, input logic wr, input logic bop,
		input logic [7:0] a, input logic [7:0] wd);
		@(posedge clk_i);
		cpu_rd_i <= rd;
		cpu_wr_i <= wr;
		cpu_bitop_i <= bop;
		cpu_addr_i <= a;
		cpu_wdata_i <= wd;
		ext_rdata_i <= 8'($urandom);
		@(posedge clk_i);
		cpu_rd_i <= 1'b0;
		cpu_wr_i <= 1'b0;
		cpu_bitop_i <= 1'b0;
		#1;
		s_sel = {ram2_sel_o, ee0_sel_o, ee1_sel_o};
		s_prd = prog_rd_o;
		s_pa = prog_addr_o;
		s_wr = mem_wr_o;
		s_ma = mem_addr_o;
		s_per = periph_sel_o;
		s_loc = local_sel_o;
		s_art = artimer_sel_o;
		s_mis = wo_misuse_o;
		@(posedge clk_i);
		#1;
		s_rv = cpu_rvalid_o;
		s_rd = cpu_rdata_o;
	endtask : op

	task automatic win(input logic [7:0] pg, input logic [5:0] o);
		op(1'b1, 1'b0, 1'b0, {2'b01, o}, 8'h00);
		chk(s_prd, 1'b1);
		chk(s_sel, 3'b000);
		chk(s_pa, {pg[5:0], o});
		chk(s_rv, 1'b1);
		chk(s_rd, pbyte({pg[5:0], o}));
	endtask : win

	task automatic bank(input logic [7:0] c);
		d = 8'($urandom);
		off = 8'($urandom);
		op(1'b0, 1'b1, 1'b0, {2'b00, off[5:0]}, d);
		chk(s_sel, exp_sel(c));
		// the write is forwarded; only the page strobes decide where it lands
		chk(s_wr, 1'b1);
		if (|exp_sel(c)) chk(s_ma[5:0], off[5:0]);
		op(1'b1, 1'b0, 1'b0, {2'b00, off[5:0]}, 8'h00);
		chk(s_rd, (|exp_sel(c)) ? d : `DSW_OPEN_BUS);
	endtask : bank

	initial begin
		void'($urandom(45300));
		repeat (10) @(posedge clk_i);
		srst_i <= 1'b0;
		// window placement, corners 000h and 0fffh among random pages
		for (int i = 0; i < 12; i++) begin
			page = (i == 0) ? 8'hc0 : (i == 1) ? 8'h3f : 8'($urandom);
			off = (i == 0) ? 8'h00 : (i == 1) ? 8'h3f : 8'($urandom);
			op(1'b0, 1'b1, 1'b0, `DSW_WIN_PAGE_ADDR, page);
			win(page, off[5:0]);
		end
		// every listed code plus reserved ones; window page must survive
		foreach (codes[i]) begin
			op(1'b0, 1'b1, 1'b0, `DSW_BANK_SEL_ADDR, codes[i]);
			bank(codes[i]);
			win(page, 6'($urandom));
		end
		// standby blocks the eeprom page
		op(1'b0, 1'b1, 1'b0, `DSW_BANK_SEL_ADDR, 8'h01);
		@(posedge clk_i);
		nv_standby_i <= 1'b1;
		op(1'b1, 1'b0, 1'b0, 8'h05, 8'h00);
		chk(s_sel, 3'b000);
		chk(s_rd, `DSW_OPEN_BUS);
		@(posedge clk_i);
		nv_standby_i <= 1'b0;
		// writes into the window area go nowhere
		op(1'b0, 1'b1, 1'b0, 8'h45, 8'h3c);
		chk({s_wr, s_prd, s_sel}, 5'b00000);
		// reads and bit ops on the write-only pair
		for (int i = 0; i < 2; i++) begin
			off = i ? `DSW_BANK_SEL_ADDR : `DSW_WIN_PAGE_ADDR;
			op(1'b1, 1'b0, 1'b0, off, 8'h00);
			chk({s_mis, s_per}, 2'b10);
			chk(s_rd, `DSW_OPEN_BUS);
			op(1'b0, 1'b1, 1'b1, off, ~page);
			chk({s_mis, s_per}, 2'b10);
		end
		win(page, 6'h2a);
		bank(8'h01);
		// timer status/control pair in the peripheral map
		for (int i = 0; i < 3; i++) begin
			op(1'b1, 1'b0, 1'b0, 8'hd5 + 8'(i), 8'h00);
			chk(s_per, 1'b1);
			chk(s_art, (i == 0) ? 2'b00 : 2'(i));
			chk(s_rd, ext_rdata_i);
		end
		// core registers, data ram and accumulator decode as local
		for (int i = 0; i < 2; i++) begin
			op(1'b1, 1'b0, 1'b0, i ? 8'hff : 8'h85, 8'h00);
			chk({s_loc, s_per}, 2'b10);
			chk(s_rd, ext_rdata_i);
		end
		// both selections ride through a reset
		op(1'b0, 1'b1, 1'b0, `DSW_BANK_SEL_ADDR, 8'h10);
		@(posedge clk_i);
		srst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		srst_i <= 1'b0;
		win(page, 6'h11);
		bank(8'h10);
		conclude();
	end
endmodule : dsw_top_tb

// file: rtl/dsw_bank_decode.sv
/*
 * turns the bank select byte into the page mapped at 00h..3fh.
 * assumes software sets at most one bit; anything else maps nothing.
 */
`timescale 1ns/10ps
module dsw_bank_decode
	import dsw_pkg::*;
#(
	parameter int EE_PAGES = 2
) (
	input wire logic [7:0] bank_i,
	output dsw_page_type page_o
);

`include "dsw_params.svh"

	// only the exact one-hot codes select; a page that is absent is none
	function automatic dsw_page_type dsw_decode(input logic [7:0] code);
		dsw_page_type p;
		p = DSW_PAGE_NONE;
		case (code)
			`DSW_CODE_RAM2: p = DSW_PAGE_RAM2;
			`DSW_CODE_EE0: p = (EE_PAGES > 0) ? DSW_PAGE_EE0 : DSW_PAGE_NONE;
			`DSW_CODE_EE1: p = (EE_PAGES > 1) ? DSW_PAGE_EE1 : DSW_PAGE_NONE;
			default: p = DSW_PAGE_NONE;
		endcase
		return p;
	endfunction : dsw_decode

	assign page_o = dsw_decode(bank_i);

endmodule : dsw_bank_decode

// file: rtl/dsw_params.svh
/*
 * constants for the data-space window and bank switch: address map,
 * register offsets, field positions, codes and pipeline timing.
 * assumes an 8-bit data space and a 12-bit program space.
 */
`ifndef DSW_PARAMS_SVH
`define DSW_PARAMS_SVH

// data-space address map
`define DSW_BANK_LO 8'h00
`define DSW_BANK_HI 8'h3f
`define DSW_WIN_LO 8'h40
`define DSW_WIN_HI 8'h7f
`define DSW_LOCAL_LO 8'h80
`define DSW_LOCAL_HI 8'hbf
`define DSW_PERIPH_LO 8'hc0
`define DSW_PERIPH_HI 8'hfe
`define DSW_ACC_ADDR 8'hff

// write-only selection registers
`define DSW_WIN_PAGE_ADDR 8'hc9
`define DSW_BANK_SEL_ADDR 8'he8

// auto-reload timer status/control pair
`define DSW_ART_SC1_ADDR 8'hd6
`define DSW_ART_SC2_ADDR 8'hd7

// field layout
`define DSW_OFFSET_W 6
`define DSW_WIN_PAGE_W 6
`define DSW_PROG_AW 12
`define DSW_RAM2_BIT 4
`define DSW_EE1_BIT 1
`define DSW_EE0_BIT 0

// bank select codes
`define DSW_CODE_NONE 8'h00
`define DSW_CODE_EE0 8'h01
`define DSW_CODE_EE1 8'h02
`define DSW_CODE_RAM2 8'h10

// value returned for unbacked reads
`define DSW_OPEN_BUS 8'hff

// cycles from a taken read to its data
`define DSW_RD_LATENCY 2

`endif

// file: rtl/dsw_pkg.sv
/*
 * types shared by the data-space window and bank switch.
 * assumes dsw_params.svh for numeric constants.
 */
package dsw_pkg;

	// where a data-space access lands
	typedef enum logic [2:0] {
		DSW_SRC_NONE = 3'b000,
		DSW_SRC_WINDOW = 3'b001,
		DSW_SRC_RAM2 = 3'b010,
		DSW_SRC_EE = 3'b011,
		DSW_SRC_EXT = 3'b100,
		DSW_SRC_WO = 3'b101
	} dsw_src_type;

	// page mapped into the bank region
	typedef enum logic [1:0] {
		DSW_PAGE_NONE = 2'b00,
		DSW_PAGE_RAM2 = 2'b01,
		DSW_PAGE_EE0 = 2'b10,
		DSW_PAGE_EE1 = 2'b11
	} dsw_page_type;

endpackage : dsw_pkg

// file: rtl/dsw_top.sv
/*
 * data-space decoder: read-only window onto program memory at 40h..7fh
 * and a bank switch paging extra ram or eeprom into 00h..3fh.
 * assumes the cpu core and all memories run on clk_i; memories answer
 * combinationally in the cycle their strobe is high.
 */
`timescale 1ns/10ps

// Functional notes
// R1: reads at 40h..7fh come from program memory, never from ram.
// R2: program address is window page above six low data-address bits.
// R3: window moves in 64-byte steps across 12-bit program space to 0fffh.
// R4: window page at c9h is write-only; no reads or bit operations.
// R5: only bits 5..0 of the window page are kept and used.
// R6: window page is not cleared by reset; software writes it first.
// R7: bank select at e8h is write-only; no reads or bit operations.
// R8: bank bit 4 (code 10h) maps the second ram page.
// R9: code 01 maps eeprom page 0, 02 page 1 if present, 00 none.
// R10: accesses at 00h..3fh go to the selected page at that offset.
// R11: software sets at most one bank select bit at a time.
// R12: bank select is not cleared at reset; software writes it first.
// R13: selection registers change only on writes, never on calls or irqs.
// R14: software keeps ram images of these registers, written first.
// R15: software keeps the eeprom page fixed during parallel writing.
// R16: auto-reload timer status/control registers decode at d6h and d7h.
// R17: each extra page is 64 bytes, seen at 00h..3fh.
// R18: eeprom pages are not strobed while eeprom standby is set.
// R19: reserved codes map nothing; reading write-only registers reads ffh.
module dsw_top
	import dsw_pkg::*;
#(
	parameter int EE_PAGES = 2
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [7:0] cpu_addr_i,
	input wire logic cpu_rd_i,
	input wire logic cpu_wr_i,
	input wire logic cpu_bitop_i,
	input wire logic [7:0] cpu_wdata_i,
	output logic [7:0] cpu_rdata_o,
	output logic cpu_rvalid_o,
	output logic [11:0] prog_addr_o,
	output logic prog_rd_o,
	input wire logic [7:0] prog_rdata_i,
	output logic [7:0] mem_addr_o,
	output logic [7:0] mem_wdata_o,
	output logic mem_wr_o,
	output logic ram2_sel_o,
	output logic ee0_sel_o,
	output logic ee1_sel_o,
	input wire logic [7:0] ram2_rdata_i,
	input wire logic [7:0] ee_rdata_i,
	input wire logic nv_standby_i,
	output logic local_sel_o,
	output logic periph_sel_o,
	output logic [1:0] artimer_sel_o,
	input wire logic [7:0] ext_rdata_i,
	output logic wo_misuse_o
);

`include "dsw_params.svh"

	logic [`DSW_WIN_PAGE_W-1:0] win_page;
	logic [7:0] bank_sel;
	dsw_page_type page;
	logic win_page_wr;
	logic bank_sel_wr;
	logic acc;

	// stage 1 (strobes to memories) and stage 2 (answer to cpu)
	logic [11:0] next_prog_addr;
	logic next_prog_rd;
	logic [7:0] next_mem_addr;
	logic [7:0] next_mem_wdata;
	logic next_mem_wr;
	logic next_ram2_sel;
	logic next_ee0_sel;
	logic next_ee1_sel;
	logic next_local_sel;
	logic next_periph_sel;
	logic [1:0] next_artimer_sel;
	logic next_misuse;
	logic rd_pend;
	logic next_rd_pend;
	dsw_src_type src;
	dsw_src_type next_src;
	logic [7:0] next_rdata;
	logic next_rvalid;

	function automatic logic in_range(input logic [7:0] a,
		input logic [7:0] lo, input logic [7:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction : in_range

	assign acc = cpu_rd_i | cpu_wr_i;

	// bit operations would read the register first, so they never write
	assign win_page_wr = cpu_wr_i && !cpu_bitop_i &&
		(cpu_addr_i == `DSW_WIN_PAGE_ADDR); // see R4
	assign bank_sel_wr = cpu_wr_i && !cpu_bitop_i &&
		(cpu_addr_i == `DSW_BANK_SEL_ADDR); // see R7

	// window page keeps only bits 5..0; no reset, see R6 and R13
	dsw_wo_reg #(
		.W(`DSW_WIN_PAGE_W)
	) u_win_page (
		.clk_i(clk_i),
		.wr_i(win_page_wr),
		.wdata_i(cpu_wdata_i[`DSW_WIN_PAGE_W-1:0]), // see R5
		.value_o(win_page)
	);

	// bank select holds the whole byte so reserved codes decode to none
	dsw_wo_reg #(
		.W(8)
	) u_bank_sel (
		.clk_i(clk_i),
		.wr_i(bank_sel_wr), // see R12
		.wdata_i(cpu_wdata_i),
		.value_o(bank_sel)
	);

	dsw_bank_decode #(
		.EE_PAGES(EE_PAGES)
	) u_bank_decode (
		.bank_i(bank_sel),
		.page_o(page)
	);

	// address decode of the request taken this cycle
	always_comb begin
		next_prog_addr = prog_addr_o;
		next_prog_rd = 1'b0;
		next_mem_addr = cpu_addr_i;
		next_mem_wdata = cpu_wdata_i;
		next_mem_wr = 1'b0;
		next_ram2_sel = 1'b0;
		next_ee0_sel = 1'b0;
		next_ee1_sel = 1'b0;
		next_local_sel = 1'b0;
		next_periph_sel = 1'b0;
		next_artimer_sel = 2'b00;
		next_misuse = 1'b0;
		next_rd_pend = cpu_rd_i;
		next_src = DSW_SRC_NONE;
		if (acc) begin
			next_mem_wr = cpu_wr_i;
			if (in_range(cpu_addr_i, `DSW_BANK_LO, `DSW_BANK_HI)) begin
				// offset within the 64-byte page, see R10 and R17
				case (page)
					DSW_PAGE_RAM2: begin
						next_ram2_sel = 1'b1; // see R8
						next_src = DSW_SRC_RAM2;
					end
					DSW_PAGE_EE0: begin
						next_ee0_sel = !nv_standby_i; // see R9, R18
						next_src = nv_standby_i ? DSW_SRC_NONE : DSW_SRC_EE;
					end
					DSW_PAGE_EE1: begin
						next_ee1_sel = !nv_standby_i; // see R9, R18
						next_src = nv_standby_i ? DSW_SRC_NONE : DSW_SRC_EE;
					end
					default: begin
						next_src = DSW_SRC_NONE; // see R19
					end
				endcase
			end else if (in_range(cpu_addr_i, `DSW_WIN_LO, `DSW_WIN_HI)) begin
				// read-only window: writes land nowhere
				next_mem_wr = 1'b0;
				if (cpu_rd_i) begin
					next_prog_rd = 1'b1; // see R1
					next_prog_addr = {win_page,
						cpu_addr_i[`DSW_OFFSET_W-1:0]}; // see R2, R3
					next_src = DSW_SRC_WINDOW;
				end
			end else if (cpu_addr_i == `DSW_WIN_PAGE_ADDR ||
				cpu_addr_i == `DSW_BANK_SEL_ADDR) begin
				// reads and bit operations here are software faults
				next_mem_wr = 1'b0;
				next_misuse = cpu_rd_i || cpu_bitop_i; // see R4, R7
				next_src = DSW_SRC_WO; // see R19
			end else if (in_range(cpu_addr_i, `DSW_LOCAL_LO,
				`DSW_LOCAL_HI) || cpu_addr_i == `DSW_ACC_ADDR) begin
				next_local_sel = 1'b1;
				next_src = DSW_SRC_EXT;
			end else begin
				next_periph_sel = 1'b1;
				next_artimer_sel[0] = (cpu_addr_i == `DSW_ART_SC1_ADDR); // see R16
				next_artimer_sel[1] = (cpu_addr_i == `DSW_ART_SC2_ADDR); // see R16
				next_src = DSW_SRC_EXT;
			end
		end
	end

	// stage 1 registers
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			prog_addr_o <= 12'h000;
			prog_rd_o <= 1'b0;
			mem_addr_o <= 8'h00;
			mem_wdata_o <= 8'h00;
			mem_wr_o <= 1'b0;
			ram2_sel_o <= 1'b0;
			ee0_sel_o <= 1'b0;
			ee1_sel_o <= 1'b0;
			local_sel_o <= 1'b0;
			periph_sel_o <= 1'b0;
			artimer_sel_o <= 2'b00;
			wo_misuse_o <= 1'b0;
			rd_pend <= 1'b0;
			src <= DSW_SRC_NONE;
		end else begin
			prog_addr_o <= next_prog_addr;
			prog_rd_o <= next_prog_rd;
			mem_addr_o <= next_mem_addr;
			mem_wdata_o <= next_mem_wdata;
			mem_wr_o <= next_mem_wr;
			ram2_sel_o <= next_ram2_sel;
			ee0_sel_o <= next_ee0_sel;
			ee1_sel_o <= next_ee1_sel;
			local_sel_o <= next_local_sel;
			periph_sel_o <= next_periph_sel;
			artimer_sel_o <= next_artimer_sel;
			wo_misuse_o <= next_misuse;
			rd_pend <= next_rd_pend;
			src <= next_src;
		end
	end

	// capture the answering source; unbacked reads see the open bus
	always_comb begin
		next_rvalid = rd_pend;
		next_rdata = cpu_rdata_o;
		if (rd_pend) begin
			case (src)
				DSW_SRC_WINDOW: next_rdata = prog_rdata_i; // see R1
				DSW_SRC_RAM2: next_rdata = ram2_rdata_i;
				DSW_SRC_EE: next_rdata = ee_rdata_i;
				DSW_SRC_EXT: next_rdata = ext_rdata_i;
				DSW_SRC_WO: next_rdata = `DSW_OPEN_BUS; // see R19
				default: next_rdata = `DSW_OPEN_BUS;
			endcase
		end
	end

	// stage 2 registers
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cpu_rdata_o <= 8'h00;
			cpu_rvalid_o <= 1'b0;
		end else begin
			cpu_rdata_o <= next_rdata;
			cpu_rvalid_o <= next_rvalid;
		end
	end

	// window reads reach program memory, never the ram strobes
	chk_win_prog_rd: assert property (@(posedge clk_i) // see R1
		disable iff (srst_i)
		cpu_rd_i && in_range(cpu_addr_i, `DSW_WIN_LO, `DSW_WIN_HI)
		|=> prog_rd_o && !local_sel_o && !ram2_sel_o && !mem_wr_o)
		else $error("window read not sent to program memory");

	chk_win_addr: assert property (@(posedge clk_i) disable iff (srst_i) // see R2
		cpu_rd_i && in_range(cpu_addr_i, `DSW_WIN_LO, `DSW_WIN_HI)
		|=> prog_addr_o == {$past(win_page), $past(cpu_addr_i[5:0])})
		else $error("window program address wrong");

	chk_win_data: assert property (@(posedge clk_i) disable iff (srst_i) // see R1
		prog_rd_o |=> cpu_rvalid_o && cpu_rdata_o == $past(prog_rdata_i))
		else $error("window data not returned");

	chk_win_page_wr: assert property (@(posedge clk_i) // see R5
		disable iff (srst_i)
		cpu_wr_i && !cpu_bitop_i && cpu_addr_i == `DSW_WIN_PAGE_ADDR
		|=> win_page == $past(cpu_wdata_i[5:0]))
		else $error("window page write lost");

	// case equality: the unwritten register must also hold its unknown value
	chk_bank_hold: assert property (@(posedge clk_i) // see R13
		disable iff (srst_i)
		!bank_sel_wr |=> bank_sel === $past(bank_sel))
		else $error("bank select changed without a write");

	chk_bitop_ignored: assert property (@(posedge clk_i) // see R7
		disable iff (srst_i)
		cpu_wr_i && cpu_bitop_i && cpu_addr_i == `DSW_BANK_SEL_ADDR
		|=> wo_misuse_o && bank_sel == $past(bank_sel))
		else $error("bit operation altered bank select");

	chk_bank_ram2: assert property (@(posedge clk_i) // see R8
		disable iff (srst_i)
		acc && cpu_addr_i <= `DSW_BANK_HI && bank_sel == `DSW_CODE_RAM2
		|=> ram2_sel_o && !ee0_sel_o && !ee1_sel_o
		&& mem_addr_o[5:0] == $past(cpu_addr_i[5:0]))
		else $error("ram page 2 not selected");

	chk_bank_ee0: assert property (@(posedge clk_i) disable iff (srst_i) // see R9
		acc && cpu_addr_i <= `DSW_BANK_HI && bank_sel == `DSW_CODE_EE0
		&& !nv_standby_i |=> ee0_sel_o && !ram2_sel_o)
		else $error("eeprom page 0 not selected");

	chk_ee_standby: assert property (@(posedge clk_i) // see R18
		disable iff (srst_i)
		acc && nv_standby_i |=> !ee0_sel_o && !ee1_sel_o)
		else $error("eeprom strobed in standby");

	chk_reserved_none: assert property (@(posedge clk_i) // see R19
		disable iff (srst_i)
		acc && cpu_addr_i <= `DSW_BANK_HI && bank_sel != `DSW_CODE_RAM2
		&& bank_sel != `DSW_CODE_EE0 && bank_sel != `DSW_CODE_EE1
		|=> !ram2_sel_o && !ee0_sel_o && !ee1_sel_o)
		else $error("reserved bank code mapped a page");

	chk_wo_read: assert property (@(posedge clk_i) disable iff (srst_i) // see R19
		cpu_rd_i && cpu_addr_i == `DSW_WIN_PAGE_ADDR
		|-> ##2 cpu_rvalid_o && cpu_rdata_o == `DSW_OPEN_BUS)
		else $error("write-only read not open bus");

	chk_art_sel: assert property (@(posedge clk_i) disable iff (srst_i) // see R16
		acc && (cpu_addr_i == `DSW_ART_SC1_ADDR
		|| cpu_addr_i == `DSW_ART_SC2_ADDR)
		|=> periph_sel_o && artimer_sel_o != 2'b00)
		else $error("timer status register not decoded");

endmodule : dsw_top

// file: rtl/dsw_wo_reg.sv
/*
 * write-only byte register without reset; holds its value until the
 * next whole-byte write. assumes the caller qualifies the write strobe.
 */
`timescale 1ns/10ps
module dsw_wo_reg #(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic wr_i,
	input wire logic [W-1:0] wdata_i,
	output logic [W-1:0] value_o
);

	logic [W-1:0] value;
	logic [W-1:0] next_value;

	// only a write changes it: no save or switch on calls or interrupts
	always_comb begin
		next_value = value;
		if (wr_i) begin
			next_value = wdata_i;
		end
	end

	// deliberately unreset: contents are undefined until software writes
	always_ff @(posedge clk_i) begin
		value <= next_value;
	end

	assign value_o = value;

endmodule : dsw_wo_reg
